/* rtl/rss_strap_map.svh */
`ifndef RSS_STRAP_MAP_SVH
`define RSS_STRAP_MAP_SVH

// Strap bit positions inside the latched strap vector
`define RSS_BIT_BOOT 0
`define RSS_BIT_IRQ 1
`define RSS_BIT_LINKW 2
`define RSS_BIT_SYSWE 3
`define RSS_BIT_TM1 4
`define RSS_BIT_TM2 5
`define RSS_BIT_TM3 6
`define RSS_NUM_STRAPS 7

// Default strap levels given by the reset-time pulls (TM pins pulled up)
`define RSS_STRAP_DEFAULT 7'h70

// Reset-time pull pattern: pull-down on the first four, pull-up on test pins
`define RSS_RST_PULL_UP 7'h70
`define RSS_RST_PULL_DN 7'h0f
// Normal-operation pull pattern: pull-up on boot-select and bus-lock only
`define RSS_RUN_PULL_UP 7'h09
`define RSS_RUN_PULL_DN 7'h00

// Last settle count before handing pins back to their normal function (settle lasts five cycles)
`define RSS_SETTLE_CYCLES 4'h4

// APB register byte offsets
`define RSS_ADDR_STATUS 12'h000
`define RSS_ADDR_SYSCFG 12'h004
`define RSS_ADDR_MEMCFG 12'h008
`define RSS_ADDR_DRIVE 12'h00c
`define RSS_ADDR_LOCK 12'h010

// Reset values
`define RSS_SYSCFG_RESET 32'h0000_0000
`define RSS_MEMCFG_RESET 32'h0000_0000
`define RSS_DRIVE_RESET 5'h00

// Field positions in the status register
`define RSS_STAT_READY 8
`define RSS_STAT_DRIVEN 9

// Processor identifier that owns the boot-select and bus-lock pulls
`define RSS_PULL_OWNER_ID 3'h0

`endif

/* rtl/rss_pkg.sv */
`default_nettype none

package rss_pkg;

  // Phase of the strap sequence around reset release
  typedef enum logic [1:0] {
    RSS_PH_RESET = 2'b00,
    RSS_PH_CAPTURE = 2'b01,
    RSS_PH_SETTLE = 2'b10,
    RSS_PH_RUN = 2'b11
  } rss_phase_t;

endpackage

`default_nettype wire

/* rtl/rss_sync2.sv */
`default_nettype none

// Two-stage synchroniser without reset, so it keeps tracking the pins
// while the block is held in reset and holds their level at release.
module rss_sync2 #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        meta[i] <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* rtl/rss_strap_sampler.sv */
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
`include "rss_strap_map.svh"

// Operation
// RULE1 - During reset all strap pins are inputs
// RULE2 - Latch every strap level at reset release
// RULE3 - Soon after release, pins resume normal use
// RULE4 - Internal pulls give default when undriven
// RULE5 - Boot strap: ROM boot or wait external
// RULE6 - Interrupt strap: disabled edge or enabled level
// RULE7 - Link width strap: 1-bit or 4-bit receive
// RULE8 - Lock strap: config registers write-once or always
// RULE9 - Board never overdrives the test-mode straps
// RULE10 - Pad pulls switch, driven pins enabled after reset
// RULE11 - Boot-select, bus-lock pulls only for identifier zero
// RULE12 - Latched straps constant until next reset
module rss_strap_sampler #(
  parameter int SETTLE_WIDTH = 4,
  parameter int ID_WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor identifier pins
  input wire logic [ID_WIDTH-1:0] proc_id,
  // Shared strap pins
  input wire logic boot_memory_select_pin_in,
  input wire logic bus_master_pin_in,
  input wire logic timer_expired_pin_in,
  input wire logic bus_lock_pin_in,
  input wire logic link1_block_complete_out_in,
  input wire logic link2_block_complete_out_in,
  input wire logic link3_block_complete_out_in,
  output logic bus_master_pin_out,
  output logic bus_master_pin_oe,
  output logic timer_expired_pin_out,
  output logic timer_expired_pin_oe,
  output logic link1_block_complete_out_out,
  output logic link1_block_complete_out_oe,
  output logic link2_block_complete_out_out,
  output logic link2_block_complete_out_oe,
  output logic link3_block_complete_out_out,
  output logic link3_block_complete_out_oe,
  // Pad pull controls, indexed by strap bit position
  output logic [`RSS_NUM_STRAPS-1:0] pad_pull_up_en,
  output logic [`RSS_NUM_STRAPS-1:0] pad_pull_dn_en,
  // Decoded settings
  output logic boot_wait_external,
  output logic irq_enable,
  output logic irq_level_sensitive,
  output logic link_rx_width_4bit,
  output logic sysreg_always_writable,
  output logic [2:0] test_mode,
  output logic config_ready,
  output logic [31:0] system_config_register,
  output logic [31:0] memory_ctrl_config_register
);

  import rss_pkg::*;

  logic [`RSS_NUM_STRAPS-1:0] pins_raw;
  logic [`RSS_NUM_STRAPS-1:0] pins_sync;
  logic [ID_WIDTH-1:0] id_sync;
  logic [ID_WIDTH-1:0] id_meta;
  logic [`RSS_NUM_STRAPS-1:0] strap;
  rss_phase_t phase;
  rss_phase_t next_phase;
  logic [SETTLE_WIDTH-1:0] settle_cnt;
  logic [4:0] drive_val;
  logic sys_written;
  logic mem_written;
  logic pull_owner;
  logic pins_driven;
  logic apb_access;
  logic apb_commit;
  logic addr_ok;
  logic wr_blocked;
  logic [31:0] rd_mux;

  // Gather the pins in strap bit order
  assign pins_raw[`RSS_BIT_BOOT] = boot_memory_select_pin_in;
  assign pins_raw[`RSS_BIT_IRQ] = bus_master_pin_in;
  assign pins_raw[`RSS_BIT_LINKW] = timer_expired_pin_in;
  assign pins_raw[`RSS_BIT_SYSWE] = bus_lock_pin_in;
  assign pins_raw[`RSS_BIT_TM1] = link1_block_complete_out_in;
  assign pins_raw[`RSS_BIT_TM2] = link2_block_complete_out_in;
  assign pins_raw[`RSS_BIT_TM3] = link3_block_complete_out_in;

  // Pins come from the board, so they cross into clk first; the
  // synchroniser keeps running during reset so its output is live at release
  rss_sync2 #(
    .WIDTH(`RSS_NUM_STRAPS)
  ) u_pin_sync (
    .clk(clk),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // Identifier pins: same two-stage crossing, no reset for the same reason
  always_ff @(posedge clk)
  begin
    id_meta <= proc_id;
    id_sync <= id_meta;
  end

  // Only the identifier-zero part owns the shared pulls; flop has no reset
  // because its value must follow the pins while reset is still held
  always_ff @(posedge clk)
  begin
    pull_owner <= (id_sync == `RSS_PULL_OWNER_ID); // RULE11
  end

  // Phase sequencing: reset -> capture -> settle -> run
  always_comb
  begin
    next_phase = phase;
    case (phase)
      RSS_PH_RESET: next_phase = RSS_PH_CAPTURE;
      RSS_PH_CAPTURE: next_phase = RSS_PH_SETTLE;
      RSS_PH_SETTLE:
      begin
        if (settle_cnt == SETTLE_WIDTH'(`RSS_SETTLE_CYCLES))
          next_phase = RSS_PH_RUN; // RULE3
      end
      RSS_PH_RUN: next_phase = RSS_PH_RUN;
      default: next_phase = RSS_PH_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      phase <= RSS_PH_RESET;
    else
      phase <= next_phase;
  end

  // Settle counter gives the pads time before they turn into drivers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settle_cnt <= '0;
    else if (phase == RSS_PH_SETTLE)
      settle_cnt <= settle_cnt + SETTLE_WIDTH'(1);
  end

  // Strap latch: defaults while in reset, loaded once at the first edge
  // after release and never again until the next reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      strap <= `RSS_STRAP_DEFAULT; // RULE4
    else if (phase == RSS_PH_RESET)
      strap <= pins_sync; // RULE2 RULE12
  end

  // Decoded settings follow the latched straps
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boot_wait_external <= 1'b0;
      irq_enable <= 1'b0;
      irq_level_sensitive <= 1'b0;
      link_rx_width_4bit <= 1'b0;
      sysreg_always_writable <= 1'b0;
      test_mode <= 3'h0;
    end
    else
    begin
      boot_wait_external <= strap[`RSS_BIT_BOOT]; // RULE5
      irq_enable <= strap[`RSS_BIT_IRQ]; // RULE6
      irq_level_sensitive <= strap[`RSS_BIT_IRQ]; // RULE6
      link_rx_width_4bit <= strap[`RSS_BIT_LINKW]; // RULE7
      sysreg_always_writable <= strap[`RSS_BIT_SYSWE]; // RULE8
      // Board keeps these at their pulled-up default
      test_mode <= strap[`RSS_BIT_TM3:`RSS_BIT_TM1]; // RULE9
    end
  end

  // Ready once the pins have gone back to normal use
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      config_ready <= 1'b0;
    else
      config_ready <= (next_phase == RSS_PH_RUN);
  end

  // Pins stay inputs until the run phase, then the five outputs drive
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pins_driven <= 1'b0; // RULE1
    else
      pins_driven <= (next_phase == RSS_PH_RUN); // RULE3 RULE10
  end

  // Output enables and levels of the driven pins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_master_pin_oe <= 1'b0; // RULE1
      timer_expired_pin_oe <= 1'b0;
      link1_block_complete_out_oe <= 1'b0;
      link2_block_complete_out_oe <= 1'b0;
      link3_block_complete_out_oe <= 1'b0;
      bus_master_pin_out <= 1'b0;
      timer_expired_pin_out <= 1'b0;
      link1_block_complete_out_out <= 1'b0;
      link2_block_complete_out_out <= 1'b0;
      link3_block_complete_out_out <= 1'b0;
    end
    else
    begin
      bus_master_pin_oe <= (next_phase == RSS_PH_RUN); // RULE10
      timer_expired_pin_oe <= (next_phase == RSS_PH_RUN);
      link1_block_complete_out_oe <= (next_phase == RSS_PH_RUN);
      link2_block_complete_out_oe <= (next_phase == RSS_PH_RUN);
      link3_block_complete_out_oe <= (next_phase == RSS_PH_RUN);
      bus_master_pin_out <= drive_val[0];
      timer_expired_pin_out <= drive_val[1];
      link1_block_complete_out_out <= drive_val[2];
      link2_block_complete_out_out <= drive_val[3];
      link3_block_complete_out_out <= drive_val[4];
    end
  end

  // Pull controls; no async reset so the owner gating holds in reset too.
  // Boot-select and bus-lock pulls are masked for non-owner identifiers.
  always_ff @(posedge clk)
  begin
    if (!pins_driven)
    begin
      pad_pull_up_en <= `RSS_RST_PULL_UP; // RULE4
      pad_pull_dn_en <= `RSS_RST_PULL_DN;
      pad_pull_dn_en[`RSS_BIT_BOOT] <= pull_owner; // RULE11
      pad_pull_dn_en[`RSS_BIT_SYSWE] <= pull_owner;
    end
    else
    begin
      pad_pull_up_en <= `RSS_RUN_PULL_UP; // RULE10
      pad_pull_dn_en <= `RSS_RUN_PULL_DN;
      pad_pull_up_en[`RSS_BIT_BOOT] <= pull_owner; // RULE11
      pad_pull_up_en[`RSS_BIT_SYSWE] <= pull_owner;
    end
  end

  // APB decode; one wait state so read data comes from a flop
  assign apb_access = psel && penable && !pready;
  assign apb_commit = psel && penable && pready;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `RSS_ADDR_STATUS:
      begin
        rd_mux[`RSS_NUM_STRAPS-1:0] = strap;
        rd_mux[`RSS_STAT_READY] = config_ready;
        rd_mux[`RSS_STAT_DRIVEN] = pins_driven;
      end
      `RSS_ADDR_SYSCFG: rd_mux = system_config_register;
      `RSS_ADDR_MEMCFG: rd_mux = memory_ctrl_config_register;
      `RSS_ADDR_DRIVE: rd_mux[4:0] = drive_val;
      `RSS_ADDR_LOCK: rd_mux[1:0] = {mem_written, sys_written};
      default: addr_ok = 1'b0;
    endcase
  end

  // Writes to the config pair are refused before run and, with the lock
  // strap low, after the first accepted write; read-only ones are refused
  always_comb
  begin
    wr_blocked = 1'b0;
    case (paddr)
      `RSS_ADDR_SYSCFG:
        wr_blocked = !config_ready || (!sysreg_always_writable && sys_written); // RULE8
      `RSS_ADDR_MEMCFG:
        wr_blocked = !config_ready || (!sysreg_always_writable && mem_written); // RULE8
      `RSS_ADDR_STATUS: wr_blocked = 1'b1;
      `RSS_ADDR_LOCK: wr_blocked = 1'b1;
      default: wr_blocked = 1'b0;
    endcase
  end

  // Handshake outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_access;
      pslverr <= apb_access && (!addr_ok || (pwrite && wr_blocked));
      prdata <= (apb_access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Config registers and their write-once flags; a write lands only at
  // the completing edge so a refused write leaves no trace
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      system_config_register <= `RSS_SYSCFG_RESET;
      memory_ctrl_config_register <= `RSS_MEMCFG_RESET;
      sys_written <= 1'b0;
      mem_written <= 1'b0;
    end
    else if (apb_commit && pwrite && !wr_blocked)
    begin
      if (paddr == `RSS_ADDR_SYSCFG)
      begin
        system_config_register <= pwdata;
        sys_written <= 1'b1; // RULE8
      end
      if (paddr == `RSS_ADDR_MEMCFG)
      begin
        memory_ctrl_config_register <= pwdata;
        mem_written <= 1'b1; // RULE8
      end
    end
  end

  // Normal-function output levels for the five driven pins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      drive_val <= `RSS_DRIVE_RESET;
    else if (apb_commit && pwrite && paddr == `RSS_ADDR_DRIVE)
      drive_val <= pwdata[4:0];
  end

endmodule

`default_nettype wire

/* verif/rss_strap_sampler_props.sv */
`default_nettype none

module rss_strap_sampler_props #(
  parameter int ID_WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ID_WIDTH-1:0] proc_id,
  input wire logic bus_master_pin_oe,
  input wire logic timer_expired_pin_oe,
  input wire logic link1_block_complete_out_oe,
  input wire logic link2_block_complete_out_oe,
  input wire logic link3_block_complete_out_oe,
  input wire logic [6:0] pad_pull_up_en,
  input wire logic [6:0] pad_pull_dn_en,
  input wire logic boot_wait_external,
  input wire logic irq_enable,
  input wire logic irq_level_sensitive,
  input wire logic link_rx_width_4bit,
  input wire logic sysreg_always_writable,
  input wire logic [2:0] test_mode,
  input wire logic config_ready,
  input wire logic [31:0] system_config_register
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic sys_done;
  logic hit;
  logic id0;
  logic [4:0] oe_v;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Commit of a system config write, and the owner test for the pulls
  assign hit = psel && penable && pready && pwrite && paddr == 12'h004;
  assign id0 = proc_id == '0;
  assign oe_v = {bus_master_pin_oe, timer_expired_pin_oe, link1_block_complete_out_oe,
    link2_block_complete_out_oe, link3_block_complete_out_oe};
  // Edges since release, saturating so long runs stay in range
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cnt <= 4'h0;
    else if (cnt != 4'hf)
      cnt <= cnt + 4'h1;
  // An accepted write arms the write-once lock
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      sys_done <= 1'b0;
    else if (hit && !pslverr)
      sys_done <= 1'b1;

  a_oe_before_run: assert property (!config_ready |-> oe_v == 5'h00)
    else $error("pin driven before run");
  a_run_timing: assert property (config_ready == (cnt >= 4'h7))
    else $error("run phase at wrong edge");
  a_drive_at_run: assert property ($rose(config_ready) |-> oe_v == 5'h1f)
    else $error("pins not driven in run");
  a_straps_hold: assert property (cnt >= 4'h3 |-> $stable({boot_wait_external,
    irq_enable, link_rx_width_4bit, sysreg_always_writable, test_mode}))
    else $error("latched strap changed");
  a_irq_pair: assert property (irq_enable == irq_level_sensitive)
    else $error("irq enable and sense differ");
  a_test_default: assert property (cnt >= 4'h3 |-> test_mode == 3'h7)
    else $error("test mode not default");
  a_pull_settle: assert property (cnt < 4'h8 |-> pad_pull_up_en == 7'h70)
    else $error("reset pulls left early");
  a_pull_run: assert property (cnt >= 4'h8 |-> pad_pull_dn_en == 7'h00
    && pad_pull_up_en == {3'h0, id0, 2'h0, id0})
    else $error("run pulls wrong");
  a_lock_once: assert property (hit && sys_done && !sysreg_always_writable |-> pslverr)
    else $error("second write accepted");
  a_refused_keep: assert property (hit && pslverr |=> $stable(system_config_register))
    else $error("refused write changed register");
endmodule

bind rss_strap_sampler rss_strap_sampler_props #(.ID_WIDTH(ID_WIDTH)) rss_strap_sampler_props_i (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .proc_id,
  .bus_master_pin_oe, .timer_expired_pin_oe, .link1_block_complete_out_oe,
  .link2_block_complete_out_oe, .link3_block_complete_out_oe, .pad_pull_up_en,
  .pad_pull_dn_en, .boot_wait_external, .irq_enable, .irq_level_sensitive,
  .link_rx_width_4bit, .sysreg_always_writable, .test_mode, .config_ready,
  .system_config_register);

`default_nettype wire

/* verif/rss_board_model.sv */
`default_nettype none

module rss_board_model (
  input wire logic clk,
  input wire logic [6:0] pull_up,
  input wire logic [6:0] pull_dn,
  input wire logic [6:0] oe,
  input wire logic [6:0] dout,
  input wire logic [6:0] drv_en,
  input wire logic [6:0] drv_val,
  output logic [6:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  logic [6:0] brd_en;
  // Floating pads wander, so a missing pull never reads as a clean level
  always_ff @(posedge clk)
    flip <= ~flip;
  // Test-mode pads are never overdriven by the board
  assign brd_en = drv_en & 7'h0f;
  // Wired level: the device driver beats the board's strap resistor,
  // which in turn beats the weak pad pull
  always_comb
    for (int i = 0; i < 7; i++)
      pin[i] = oe[i] ? dout[i] : brd_en[i] ? drv_val[i] :
        pull_up[i] ? 1'b1 : pull_dn[i] ? 1'b0 : flip;
endmodule

`default_nettype wire

/* verif/tb_reset_strap_sampler.sv */
`default_nettype none

module tb_reset_strap_sampler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] proc_id = 3'h0;
  logic [6:0] drv_en = 7'h00;
  logic [6:0] drv_val = 7'h00;
  logic [31:0] prdata, rd, scr, mcr;
  logic pready, pslverr, err, bwe, irqe, irql, lw, sw, rdy;
  logic [2:0] tm;
  logic [6:0] pin, up, dn;
  wire logic [6:0] oe_v, out_v;
  int failures = 0;
  int check_count = 0;
  // Boot-select and bus-lock are never driven by the block
  assign oe_v[0] = 1'b0;
  assign oe_v[3] = 1'b0;
  assign out_v[0] = 1'b0;
  assign out_v[3] = 1'b0;
  always #5 clk = ~clk;

  rss_strap_sampler rss_strap_sampler_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .proc_id, .boot_memory_select_pin_in(pin[0]),
    .bus_master_pin_in(pin[1]), .timer_expired_pin_in(pin[2]), .bus_lock_pin_in(pin[3]),
    .link1_block_complete_out_in(pin[4]), .link2_block_complete_out_in(pin[5]),
    .link3_block_complete_out_in(pin[6]), .bus_master_pin_out(out_v[1]),
    .bus_master_pin_oe(oe_v[1]), .timer_expired_pin_out(out_v[2]),
    .timer_expired_pin_oe(oe_v[2]), .link1_block_complete_out_out(out_v[4]),
    .link1_block_complete_out_oe(oe_v[4]), .link2_block_complete_out_out(out_v[5]),
    .link2_block_complete_out_oe(oe_v[5]), .link3_block_complete_out_out(out_v[6]),
    .link3_block_complete_out_oe(oe_v[6]), .pad_pull_up_en(up), .pad_pull_dn_en(dn),
    .boot_wait_external(bwe), .irq_enable(irqe), .irq_level_sensitive(irql),
    .link_rx_width_4bit(lw), .sysreg_always_writable(sw), .test_mode(tm),
    .config_ready(rdy), .system_config_register(scr), .memory_ctrl_config_register(mcr));

  rss_board_model rss_board_model_i (.clk, .pull_up(up), .pull_dn(dn), .oe(oe_v),
    .dout(out_v), .drv_en, .drv_val, .pin);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer taken at the rising edge that sees pready; only the watchdog
    // ends a wait that never gets one
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset with the given straps on the board, then check the latched result
  task automatic scen(input logic [2:0] id, input logic [3:0] e);
    @(posedge clk);
    rst_b <= 1'b0;
    proc_id <= id;
    drv_val <= {3'h0, ~e};
    repeat (5) @(posedge clk);
    drv_val <= {3'h7, e};
    chk("oe in reset", 32'(oe_v), 32'h0);
    chk("ready in reset", 32'(rdy), 32'h0);
    chk("pulls in reset", 32'({up, dn}), 32'({7'h70, 3'h0, id == 0, 2'h3, id == 0}));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // A config write during settle must be refused and leave no trace
    apb(1'b1, 12'h004, 32'hdead_beef);
    chk("early write err", 32'(err), 32'h1);
    repeat (4) @(posedge clk);
    drv_val <= {3'h0, ~e};
    apb(1'b0, 12'h000, 32'h0);
    chk("status", rd, {22'h0, 2'h3, 4'h7, e});
    chk("decoded", 32'({bwe, irqe, irql, lw, sw, tm}), 32'({e[0], e[1], e[1], e[2], e[3], 3'h7}));
    chk("oe run", 32'(oe_v), 32'h76);
    chk("ready run", 32'(rdy), 32'h1);
    chk("pulls run", 32'({up, dn}), 32'({id == 0 ? 7'h09 : 7'h00, 7'h00}));
    for (int a = 4; a <= 8; a += 4)
    begin
      apb(1'b1, 12'(a), 32'h1234_5678);
      chk("first write err", 32'(err), 32'h0);
      apb(1'b1, 12'(a), 32'h0bad_f00d);
      chk("second write err", 32'(err), 32'(!e[3]));
      apb(1'b0, 12'(a), 32'h0);
      chk("config read", rd, e[3] ? 32'h0bad_f00d : 32'h1234_5678);
    end
    chk("sys config out", scr, e[3] ? 32'h0bad_f00d : 32'h1234_5678);
    chk("mem config out", mcr, e[3] ? 32'h0bad_f00d : 32'h1234_5678);
    apb(1'b0, 12'h010, 32'h0);
    chk("written flags", rd, 32'h3);
    // Normal-function levels on the five driven pins
    apb(1'b1, 12'h00c, 32'h0000_0015);
    apb(1'b0, 12'h00c, 32'h0);
    chk("drive reg", rd, 32'h15);
    chk("drive outs", 32'(out_v), 32'h52);
    chk("driven pins", 32'(pin & 7'h76), 32'h52);
    apb(1'b1, 12'h000, 32'hffff_ffff);
    chk("status write err", 32'(err), 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("status kept", rd, {22'h0, 2'h3, 4'h7, e});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
  endtask

  task automatic report_and_stop;
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Defaults from the pulls, then every option strapped the other way
  initial
  begin
    scen(3'h0, 4'h0);
    drv_en <= 7'h7f;
    scen(3'h1, 4'hf);
    report_and_stop;
  end

  // Both scenarios take well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule

`default_nettype wire
